//--- logic/mscr_ctrl_regs.sv
// Modem register bank with serial control bus slave and global control.
`timescale 1ns/1ps
`include "mscr_regs.svh"

module mscr_ctrl_regs import mscr_pkg::*; #(
  parameter int unsigned SETTLE_CYCLES = `MSCR_VBIAS_SETTLE_MS * `MSCR_CLK_KHZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial control bus pins
  input wire logic cb_clk,
  input wire logic cb_sel_low,
  input wire logic cb_cmd_data,
  output logic cb_reply_data,
  output logic cb_reply_oe,
  // Device reset pin
  input wire logic chip_reset_pin_low,
  // Modem core status
  input wire logic [14:0] core_status1,
  input wire logic [15:0] core_status2,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_stb,
  input wire logic [6:0] irq_source,
  // Register contents
  output logic [15:0] general_control,
  output logic [15:0] transmit_mode,
  output logic [15:0] receive_mode,
  output logic [15:0] tone_programming,
  output logic [7:0] analogue_routing,
  output logic [7:0] transmit_data,
  output logic transmit_data_stb,
  output logic rx_data_taken,
  // Global control
  output logic tx_mode_disabled,
  output logic tx_mode_tones,
  output logic powersave,
  output logic core_reset,
  output logic equaliser_bypass,
  output logic relay_drive_out_low,
  output logic irq_out_low,
  output logic vbias_settled
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

  typedef struct packed {
    mscr_phase_t phase;
    logic clk_prev;
    logic [4:0] bit_cnt;
    logic [4:0] bit_last;
    logic [15:0] shift;
    logic [7:0] addr;
    logic [15:0] rd_sh;
    logic reply;
    logic reply_oe;
    logic gen_rst;
    logic wr_stb;
    logic [15:0] wr_data;
    logic tx_stb;
    logic [7:0] tx_data;
    logic rx_taken;
    logic irq;
    logic [14:0] st1;
    logic [15:0] st2;
    logic [7:0] rx_data;
    logic pwrsave;
    logic core_rst;
    logic eq_off;
    logic relay_n;
    logic irq_n;
    logic tx_dis;
    logic tx_tone;
    logic [15:0] txm;
    logic [CW-1:0] settle;
    logic settled;
  } mscr_main_st_t;

  mscr_main_st_t q;
  mscr_main_st_t d;

  // ==========================================================
  // Pin synchronisers
  logic [3:0] pins_s;
  logic clk_s;
  logic sel_low_s;
  logic din_s;
  logic pin_rst_low_s;

  mscr_sync #(.W(4), .INIT(4'b1110)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({chip_reset_pin_low, cb_clk, cb_sel_low, cb_cmd_data}),
    .q(pins_s)
  );

  assign pin_rst_low_s = pins_s[3];
  assign clk_s = pins_s[2];
  assign sel_low_s = pins_s[1];
  assign din_s = pins_s[0];

  // ==========================================================
  // Write-only registers
  logic [15:0] gc;
  logic [15:0] txm_q;
  logic [`MSCR_ROUTING_W-1:0] route_q;
  logic wr_gc;
  logic wr_txm;
  logic wr_rxm;
  logic wr_prog;
  logic wr_route;
  logic int_rst;

  assign wr_gc = q.wr_stb && (q.addr == `MSCR_ADDR_GEN_CTRL);
  assign wr_txm = q.wr_stb && (q.addr == `MSCR_ADDR_TX_MODE);
  assign wr_rxm = q.wr_stb && (q.addr == `MSCR_ADDR_RX_MODE);
  assign wr_prog = q.wr_stb && (q.addr == `MSCR_ADDR_PROG);
  assign wr_route = q.wr_stb && (q.addr == `MSCR_ADDR_ROUTING);
  assign int_rst = gc[`MSCR_GC_RESET];

  mscr_wreg #(.W(16)) u_gc (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(q.gen_rst),
    .hold(1'b0),
    .we(wr_gc),
    .wdata(q.wr_data),
    .q(gc)
  );

  mscr_wreg #(.W(16)) u_txm (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(q.gen_rst),
    .hold(int_rst),
    .we(wr_txm),
    .wdata(q.wr_data),
    .q(txm_q)
  );

  mscr_wreg #(.W(16)) u_rxm (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(q.gen_rst),
    .hold(int_rst),
    .we(wr_rxm),
    .wdata(q.wr_data),
    .q(receive_mode)
  );

  mscr_wreg #(.W(16)) u_prog (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(q.gen_rst),
    .hold(int_rst),
    .we(wr_prog),
    .wdata(q.wr_data),
    .q(tone_programming)
  );

  mscr_wreg #(.W(`MSCR_ROUTING_W)) u_route (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(q.gen_rst),
    .hold(int_rst),
    .we(wr_route),
    .wdata(q.wr_data[`MSCR_ROUTING_W-1:0]),
    .q(route_q)
  );

  // ==========================================================
  // Frame engine and status
  logic [15:0] nxt;
  logic clk_rise;
  logic irq_clr;
  logic irq_set;
  logic [4:0] cnt_inc;

  always_comb begin
    d = q;
    nxt = {q.shift[14:0], din_s};
    clk_rise = clk_s && !q.clk_prev;
    cnt_inc = q.bit_cnt + 5'h01;
    irq_clr = 1'b0;
    d.clk_prev = clk_s;
    d.gen_rst = !pin_rst_low_s;
    d.wr_stb = 1'b0;
    d.rx_taken = 1'b0;
    if (sel_low_s) begin
      d.phase = MSCR_IDLE;
      d.reply = 1'b0;
      d.reply_oe = 1'b0;
    end else begin
      case (q.phase)
        MSCR_IDLE: begin
          d.phase = MSCR_ADDR;
          d.bit_cnt = 5'h00;
        end
        MSCR_ADDR: begin
          if (clk_rise) begin
            d.shift = nxt;
            d.bit_cnt = cnt_inc;
            if (q.bit_cnt == `MSCR_LAST_BIT_BYTE) begin
              d.addr = nxt[7:0];
              d.bit_cnt = 5'h00;
              case (nxt[7:0])
                `MSCR_ADDR_GEN_RESET: begin
                  d.gen_rst = 1'b1;
                  d.phase = MSCR_DONE;
                end
                `MSCR_ADDR_GEN_CTRL, `MSCR_ADDR_TX_MODE, `MSCR_ADDR_RX_MODE,
                `MSCR_ADDR_PROG: begin
                  d.bit_last = `MSCR_LAST_BIT_WORD;
                  d.phase = MSCR_DATA;
                end
                `MSCR_ADDR_TX_DATA_A, `MSCR_ADDR_TX_DATA_B, `MSCR_ADDR_ROUTING: begin
                  d.bit_last = `MSCR_LAST_BIT_BYTE;
                  d.phase = MSCR_DATA;
                end
                `MSCR_ADDR_RX_DATA: begin
                  d.bit_last = `MSCR_LAST_BIT_BYTE;
                  d.rd_sh = {q.rx_data, 8'h00};
                  d.reply = q.rx_data[7];
                  d.reply_oe = 1'b1;
                  d.rx_taken = 1'b1;
                  d.phase = MSCR_READ;
                end
                `MSCR_ADDR_STATUS1: begin
                  d.bit_last = `MSCR_LAST_BIT_WORD;
                  d.rd_sh = {q.irq, q.st1};
                  d.reply = q.irq;
                  d.reply_oe = 1'b1;
                  irq_clr = 1'b1;
                  d.phase = MSCR_READ;
                end
                `MSCR_ADDR_STATUS2: begin
                  d.bit_last = `MSCR_LAST_BIT_WORD;
                  d.rd_sh = q.st2;
                  d.reply = q.st2[15];
                  d.reply_oe = 1'b1;
                  d.phase = MSCR_READ;
                end
                // Test and unmapped addresses are ignored.
                default: begin
                  d.phase = MSCR_DONE;
                end
              endcase
            end
          end
        end
        MSCR_DATA: begin
          if (clk_rise) begin
            d.shift = nxt;
            d.bit_cnt = cnt_inc;
            if (q.bit_cnt == q.bit_last) begin
              d.wr_stb = 1'b1;
              d.wr_data = (q.bit_last == `MSCR_LAST_BIT_BYTE) ? {8'h00, nxt[7:0]} : nxt;
              d.phase = MSCR_DONE;
            end
          end
        end
        // The host samples on the rising edge, so the next bit is set up
        // right after it and stays stable for a whole serial clock period.
        MSCR_READ: begin
          if (clk_rise) begin
            d.rd_sh = {q.rd_sh[14:0], 1'b0};
            d.reply = q.rd_sh[14];
            d.bit_cnt = cnt_inc;
            if (q.bit_cnt == q.bit_last) begin
              d.phase = MSCR_DONE;
            end
          end
        end
        MSCR_DONE: begin
          d.phase = MSCR_DONE;
        end
        default: begin
          d.phase = MSCR_IDLE;
        end
      endcase
    end

    d.tx_stb = q.wr_stb && ((q.addr == `MSCR_ADDR_TX_DATA_A) ||
                            (q.addr == `MSCR_ADDR_TX_DATA_B));
    if (d.tx_stb) begin
      d.tx_data = q.wr_data[7:0];
    end
    if (rx_byte_stb) begin
      d.rx_data = rx_byte;
    end

    irq_set = |(irq_source & {gc[`MSCR_GC_HOOK_MASK], gc[`MSCR_GC_MASK_HI:0]});
    d.irq = irq_set || (q.irq && !irq_clr && !q.gen_rst);

    d.st1 = core_status1;
    d.st2 = core_status2;
    if (q.gen_rst) begin
      d.st1 = core_status1 & `MSCR_ST1_KEEP_MASK;
      d.st2 = core_status2 & `MSCR_ST2_KEEP_MASK;
    end else if (int_rst) begin
      d.st1 = core_status1 & `MSCR_ST1_INTRST_MASK;
    end

    d.pwrsave = !gc[`MSCR_GC_POWERUP];
    d.core_rst = int_rst || q.gen_rst;
    d.eq_off = gc[`MSCR_GC_EQU_OFF];
    d.relay_n = !gc[`MSCR_GC_RELAY];
    d.irq_n = !(gc[`MSCR_GC_IRQ_EN] && q.irq);
    d.tx_dis = txm_q[`MSCR_TXM_MODE_HI:`MSCR_TXM_MODE_LO] == `MSCR_TXM_OFF;
    d.tx_tone = txm_q[`MSCR_TXM_MODE_HI:`MSCR_TXM_MODE_LO] == `MSCR_TXM_TONES;
    d.txm = d.tx_dis ? `MSCR_REG_RESET : txm_q;

    // Settling only counts while powered up with reset held; the flag is
    // a convenience, the host still owns the wait before using the modem.
    if (!gc[`MSCR_GC_POWERUP]) begin
      d.settle = '0;
      d.settled = 1'b0;
    end else if (int_rst && !q.settled) begin
      if (q.settle == SETTLE_LAST) begin
        d.settled = 1'b1;
      end else begin
        d.settle = q.settle + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.phase <= MSCR_IDLE;
      q.clk_prev <= 1'b1;
      q.pwrsave <= 1'b1;
      q.relay_n <= 1'b1;
      q.irq_n <= 1'b1;
      q.tx_dis <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign cb_reply_data = q.reply;
  assign cb_reply_oe = q.reply_oe;
  assign general_control = gc;
  assign transmit_mode = q.txm;
  assign analogue_routing = {2'b00, route_q};
  assign transmit_data = q.tx_data;
  assign transmit_data_stb = q.tx_stb;
  assign rx_data_taken = q.rx_taken;
  assign tx_mode_disabled = q.tx_dis;
  assign tx_mode_tones = q.tx_tone;
  assign powersave = q.pwrsave;
  assign core_reset = q.core_rst;
  assign equaliser_bypass = q.eq_off;
  assign relay_drive_out_low = q.relay_n;
  assign irq_out_low = q.irq_n;
  assign vbias_settled = q.settled;

  // ==========================================================
  // Assertions
  default clocking cb_a @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence gc_write_s;
    wr_gc && (q.wr_data != 16'h0000);
  endsequence

  sequence gen_reset_s;
    q.gen_rst;
  endsequence

  gen_reset_clear_a: assert property (gen_reset_s |=> gc == 16'h0000 && txm_q == 16'h0000 ##1 powersave)
    else $error("general reset did not clear control and enter powersave");
  ctrl_write_a: assert property (gc_write_s ##0 !q.gen_rst |=> gc == $past(q.wr_data))
    else $error("general control write not stored");
  int_reset_hold_a: assert property (int_rst |=> txm_q == 16'h0000 && route_q == 6'h00)
    else $error("internal reset did not hold registers clear");
  relay_drive_a: assert property ($rose(gc[`MSCR_GC_RELAY]) |=> !relay_drive_out_low)
    else $error("relay output not pulled low");
  irq_pin_a: assert property (gc[`MSCR_GC_IRQ_EN] && q.irq |=> !irq_out_low)
    else $error("interrupt output not asserted");
  irq_quiet_a: assert property (!gc[`MSCR_GC_IRQ_EN] |=> irq_out_low)
    else $error("interrupt output active while disabled");
  irq_set_wins_a: assert property (irq_set |=> q.irq)
    else $error("masked event lost from interrupt flag");
  equ_bypass_a: assert property (gc[`MSCR_GC_EQU_OFF] |=> equaliser_bypass)
    else $error("equaliser not bypassed");
  tx_disabled_a: assert property (txm_q[15:12] == 4'h0 |=> tx_mode_disabled && transmit_mode == 16'h0000)
    else $error("disabled transmit mode has nonzero low bits");
  route_top_a: assert property (wr_route && !int_rst && !q.gen_rst |=>
    analogue_routing == {2'b00, $past(q.wr_data[5:0])})
    else $error("reserved routing bits nonzero");

endmodule

//--- logic/mscr_pkg.sv
// Shared types of the modem control register block.
package mscr_pkg;

  // ==========================================================
  // Serial frame phases
  typedef enum logic [2:0] {
    MSCR_IDLE,
    MSCR_ADDR,
    MSCR_DATA,
    MSCR_READ,
    MSCR_DONE
  } mscr_phase_t;

endpackage

//--- logic/mscr_regs.svh
// Address map, field positions and timing constants of the modem control registers.
`ifndef MSCR_REGS_SVH
`define MSCR_REGS_SVH

// ==========================================================
// Serial control bus addresses
`define MSCR_ADDR_GEN_RESET 8'h01
`define MSCR_ADDR_GEN_CTRL 8'he0
`define MSCR_ADDR_TX_MODE 8'he1
`define MSCR_ADDR_RX_MODE 8'he2
`define MSCR_ADDR_TX_DATA_A 8'he3
`define MSCR_ADDR_TX_DATA_B 8'he4
`define MSCR_ADDR_RX_DATA 8'he5
`define MSCR_ADDR_STATUS1 8'he6
`define MSCR_ADDR_STATUS2 8'he7
`define MSCR_ADDR_PROG 8'he8
`define MSCR_ADDR_ROUTING 8'hec

// ==========================================================
// Frame lengths, counted as last bit index
`define MSCR_LAST_BIT_BYTE 5'h07
`define MSCR_LAST_BIT_WORD 5'h0f

// ==========================================================
// General control field positions
`define MSCR_GC_HOOK_MASK 11
`define MSCR_GC_EQU_OFF 10
`define MSCR_GC_RELAY 9
`define MSCR_GC_POWERUP 8
`define MSCR_GC_RESET 7
`define MSCR_GC_IRQ_EN 6
`define MSCR_GC_MASK_HI 5

// ==========================================================
// Status fields and reset values
`define MSCR_ST1_KEEP_MASK 15'h4000
`define MSCR_ST1_INTRST_MASK 15'h4000
`define MSCR_ST2_KEEP_MASK 16'h0100
`define MSCR_REG_RESET 16'h0000
`define MSCR_ROUTING_W 6

// ==========================================================
// Transmit mode field
`define MSCR_TXM_MODE_HI 15
`define MSCR_TXM_MODE_LO 12
`define MSCR_TXM_OFF 4'h0
`define MSCR_TXM_TONES 4'h1

// ==========================================================
// Timing
`define MSCR_CLK_KHZ 40000
`define MSCR_VBIAS_SETTLE_MS 20

`endif

//--- logic/mscr_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps

module mscr_sync import mscr_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and filtered levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } mscr_sync_st_t;

  mscr_sync_st_t st_q;
  mscr_sync_st_t st_d;

  // A level counts only once the second and third stages agree, so a
  // single metastable sample never reaches the frame logic.
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= {INIT, INIT, INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.lvl;

endmodule

//--- logic/mscr_wreg.sv
// Write-only register with a pulsed clear and a held clear.
`timescale 1ns/1ps

module mscr_wreg import mscr_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic hold,
  input wire logic we,
  input wire logic [W-1:0] wdata,
  // Contents
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] val;
  } mscr_wreg_st_t;

  mscr_wreg_st_t st_q;
  mscr_wreg_st_t st_d;

  // Clears beat a write in the same cycle, so nothing survives a reset.
  always_comb begin
    st_d = st_q;
    if (clr || hold) begin
      st_d.val = '0;
    end else if (we) begin
      st_d.val = wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.val;

endmodule

//--- tb/modem_serial_control_registers_test.sv
// Self-checking bench for the modem control register bank.
`timescale 1ns/1ps
`include "mscr_regs.svh"

module modem_serial_control_registers_test import mscr_pkg::*;;
  typedef logic [103:0] mscr_obs_t;
  logic sys_clk, rst, cb_clk, cb_sel_low, cb_cmd_data, cb_reply_data, cb_reply_oe;
  logic chip_reset_pin_low, rx_byte_stb, frame_done;
  logic [14:0] core_status1, st1;
  logic [15:0] core_status2, st2, rd_word, general_control, transmit_mode, receive_mode;
  logic [15:0] tone_programming, gc, tm, rm, tp;
  logic [7:0] rx_byte, analogue_routing, transmit_data, ar, td, b;
  logic [6:0] irq_source;
  logic transmit_data_stb, rx_data_taken, tx_mode_disabled, tx_mode_tones, powersave;
  logic core_reset, equaliser_bypass, relay_drive_out_low, irq_out_low, vbias_settled;
  logic flag, both;
  mscr_obs_t note_q[$];
  int err_count, n_checks, cyc, n_tx_stb, n_rx_taken;

  mscr_ctrl_regs #(.SETTLE_CYCLES(20)) mscr_ctrl_regs_inst (.sys_clk(sys_clk), .rst(rst),
    .cb_clk(cb_clk), .cb_sel_low(cb_sel_low), .cb_cmd_data(cb_cmd_data),
    .cb_reply_data(cb_reply_data), .cb_reply_oe(cb_reply_oe),
    .chip_reset_pin_low(chip_reset_pin_low), .core_status1(core_status1),
    .core_status2(core_status2), .rx_byte(rx_byte), .rx_byte_stb(rx_byte_stb),
    .irq_source(irq_source), .general_control(general_control),
    .transmit_mode(transmit_mode), .receive_mode(receive_mode),
    .tone_programming(tone_programming), .analogue_routing(analogue_routing),
    .transmit_data(transmit_data), .transmit_data_stb(transmit_data_stb),
    .rx_data_taken(rx_data_taken), .tx_mode_disabled(tx_mode_disabled),
    .tx_mode_tones(tx_mode_tones), .powersave(powersave), .core_reset(core_reset),
    .equaliser_bypass(equaliser_bypass), .relay_drive_out_low(relay_drive_out_low),
    .irq_out_low(irq_out_low), .vbias_settled(vbias_settled));

  mscr_host_model mscr_host_model_inst (.sys_clk(sys_clk), .cb_clk(cb_clk),
    .cb_sel_low(cb_sel_low), .cb_cmd_data(cb_cmd_data), .cb_reply_data(cb_reply_data),
    .cb_reply_oe(cb_reply_oe), .frame_done(frame_done), .rd_word(rd_word));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input mscr_obs_t seen, input mscr_obs_t exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks: %0d, mismatches: %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Outputs are compared once the host has closed a frame and everything has settled.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (transmit_data_stb === 1'b1) n_tx_stb <= n_tx_stb + 1;
    if (rx_data_taken === 1'b1) n_rx_taken <= n_rx_taken + 1;
    if (frame_done === 1'b1) begin
      check({general_control, transmit_mode, receive_mode, tone_programming, analogue_routing,
        transmit_data, powersave, core_reset, equaliser_bypass, relay_drive_out_low,
        irq_out_low, tx_mode_disabled, tx_mode_tones, vbias_settled, rd_word},
        note_q.pop_front());
    end
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Expectation model and stimulus tasks
  function automatic mscr_obs_t snap(input logic [15:0] rd, input logic vb);
    snap = {gc, tm, rm, tp, ar, td, ~gc[8], gc[7], gc[10], ~gc[9], ~(gc[6] & flag),
      tm[15:12] == `MSCR_TXM_OFF, tm[15:12] == `MSCR_TXM_TONES, vb, rd};
  endfunction

  task automatic clr_all();
    {gc, tm, rm, tp, ar, flag, both} = '0;
  endtask

  task automatic op(input logic [7:0] a, input logic [15:0] d, input int nd, input int nr,
    input logic [15:0] rd);
    logic vb_old;
    int wd;
    vb_old = gc[8] & gc[7];
    wd = (a == `MSCR_ADDR_GEN_RESET) ? 0 : ((a inside {`MSCR_ADDR_TX_DATA_A,
      `MSCR_ADDR_TX_DATA_B, `MSCR_ADDR_ROUTING}) ? 8 : 16);
    if (nr == 0 && nd == wd) begin
      case (a)
        `MSCR_ADDR_GEN_RESET: clr_all();
        `MSCR_ADDR_GEN_CTRL: gc = d;
        `MSCR_ADDR_TX_MODE: tm = (d[15:12] == `MSCR_TXM_OFF) ? 16'h0000 : d;
        `MSCR_ADDR_RX_MODE: rm = d;
        `MSCR_ADDR_PROG: tp = d;
        `MSCR_ADDR_ROUTING: ar = {2'b00, d[5:0]};
        `MSCR_ADDR_TX_DATA_A, `MSCR_ADDR_TX_DATA_B: td = d[7:0];
        default: ;
      endcase
    end
    // internal reset holds the mode and path registers clear
    if (gc[7]) {tm, rm, tp, ar} = '0;
    if (a == `MSCR_ADDR_STATUS1 && nr > 0) flag = 1'b0;
    // Settled needs a whole frame with both bits set and is kept until powerup drops.
    both = gc[8] & (both | (vb_old & gc[7]));
    note_q.push_back(snap(rd, both));
    mscr_host_model_inst.xfer((24'(a) << nd) | (24'(d) & ((24'h1 << nd) - 24'h1)), 8 + nd, nr);
  endtask

  task automatic pulse_irq(input logic [6:0] s);
    @(posedge sys_clk);
    irq_source <= s;
    @(posedge sys_clk);
    irq_source <= 7'h00;
    flag = flag | (|(s & {gc[11], gc[5:0]}));
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst, chip_reset_pin_low} = 2'b11;
    {core_status1, core_status2, rx_byte, rx_byte_stb, irq_source} = '0;
    {td, b} = '0;
    clr_all();
    void'($urandom(32'h9cc5));
    st1 = 15'($urandom);
    st2 = 16'($urandom);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    core_status1 <= st1;
    core_status2 <= st2;
    repeat (8) @(posedge sys_clk);
    op(`MSCR_ADDR_GEN_RESET, 16'h0000, 0, 0, 16'h0000);
    // powerup with internal reset held; top four bits stay zero
    op(`MSCR_ADDR_GEN_CTRL, 16'h0180, 16, 0, 16'h0000);
    op(`MSCR_ADDR_TX_MODE, 16'h5abc, 16, 0, 16'h0000);
    op(`MSCR_ADDR_ROUTING, 16'h002a, 8, 0, 16'h0000);
    op(`MSCR_ADDR_GEN_CTRL, 16'h0500, 16, 0, 16'h0000);
    // Fields a mode leaves unused stay zero; disabled mode keeps noise to test forcing.
    for (int m = 0; m < 16; m++) begin
      logic [11:0] msk;
      msk = (m == 1) ? 12'hee0 : ((m > 1 && m < 10) ? 12'he1f : 12'hfff);
      op(`MSCR_ADDR_TX_MODE, {4'(m), 12'($urandom) & msk}, 16, 0, 16'h0000);
    end
    op(`MSCR_ADDR_RX_MODE, 16'($urandom), 16, 0, 16'h0000);
    op(`MSCR_ADDR_PROG, 16'($urandom), 16, 0, 16'h0000);
    mscr_host_model_inst.half = 14;
    op(`MSCR_ADDR_ROUTING, {10'h000, 6'($urandom)}, 8, 0, 16'h0000);
    mscr_host_model_inst.half = 8;
    op(`MSCR_ADDR_TX_DATA_A, {8'h00, 8'($urandom)}, 8, 0, 16'h0000);
    op(`MSCR_ADDR_TX_DATA_B, {8'h00, 8'($urandom)}, 8, 0, 16'h0000);
    // Unmapped addresses only; the production test addresses are never touched.
    op(8'hed, 16'($urandom), 16, 0, 16'h0000);
    op(8'hf0, 16'($urandom), 16, 0, 16'h0000);
    // A frame cut short after twelve data bits must not write.
    op(`MSCR_ADDR_GEN_CTRL, 16'h0fff, 12, 0, 16'h0000);
    op(`MSCR_ADDR_GEN_CTRL, 16'h0280, 16, 0, 16'h0000);
    b = 8'($urandom);
    @(posedge sys_clk);
    rx_byte <= b;
    rx_byte_stb <= 1'b1;
    @(posedge sys_clk);
    rx_byte_stb <= 1'b0;
    op(`MSCR_ADDR_RX_DATA, 16'h0000, 0, 8, {8'h00, b});
    op(`MSCR_ADDR_STATUS2, 16'h0000, 0, 16, st2);
    op(`MSCR_ADDR_STATUS1, 16'h0000, 0, 16, {flag, st1[14], 14'h0000});
    op(`MSCR_ADDR_GEN_CTRL, 16'h0841, 16, 0, 16'h0000);
    pulse_irq(7'h02);
    op(`MSCR_ADDR_ROUTING, 16'h0015, 8, 0, 16'h0000);
    pulse_irq(7'h40);
    op(`MSCR_ADDR_PROG, 16'h1234, 16, 0, 16'h0000);
    op(`MSCR_ADDR_STATUS1, 16'h0000, 0, 16, {flag, st1});
    op(`MSCR_ADDR_GEN_CTRL, 16'h0801, 16, 0, 16'h0000);
    pulse_irq(7'h01);
    op(`MSCR_ADDR_ROUTING, 16'h0033, 8, 0, 16'h0000);
    op(`MSCR_ADDR_GEN_RESET, 16'h0000, 0, 0, 16'h0000);
    op(`MSCR_ADDR_GEN_CTRL, 16'h0300, 16, 0, 16'h0000);
    chip_reset_pin_low <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chip_reset_pin_low <= 1'b1;
    clr_all();
    repeat (8) @(posedge sys_clk);
    op(`MSCR_ADDR_GEN_CTRL, 16'h0000, 4, 0, 16'h0000);
    // Let the checker take the last note before closing.
    repeat (4) @(posedge sys_clk);
    check(n_tx_stb, 2);
    check(n_rx_taken, 1);
    check(note_q.size(), 0);
    complete_run();
  end
endmodule

//--- tb/mscr_host_model.sv
// Host-side serial control bus controller model.
`timescale 1ns/1ps

module mscr_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial control bus
  output logic cb_clk,
  output logic cb_sel_low,
  output logic cb_cmd_data,
  input wire logic cb_reply_data,
  input wire logic cb_reply_oe,
  // Frame results
  output logic frame_done,
  output logic [15:0] rd_word
);
  // Half period in system clocks; the bench raises it for a slow host.
  int half = 8;

  initial begin
    cb_clk = 1'b1;
    cb_sel_low = 1'b1;
    cb_cmd_data = 1'b0;
    frame_done = 1'b0;
    rd_word = 16'h0000;
  end

  // ==========================================================
  // Frame engine
  // The clock stands high outside frames and the idle data line toggles.
  task automatic xfer(input logic [23:0] wv, input int nw, input int nr);
    logic [15:0] rd;
    rd = 16'h0000;
    @(posedge sys_clk);
    cb_sel_low <= 1'b0;
    repeat (half) @(posedge sys_clk);
    for (int i = nw - 1; i >= 0; i--) begin
      cb_clk <= 1'b0;
      cb_cmd_data <= wv[i];
      repeat (half) @(posedge sys_clk);
      cb_clk <= 1'b1;
      repeat (half) @(posedge sys_clk);
    end
    for (int i = 0; i < nr; i++) begin
      cb_clk <= 1'b0;
      cb_cmd_data <= ~cb_cmd_data;
      repeat (half) @(posedge sys_clk);
      rd = {rd[14:0], cb_reply_oe ? cb_reply_data : 1'bx};
      cb_clk <= 1'b1;
      repeat (half) @(posedge sys_clk);
    end
    cb_sel_low <= 1'b1;
    cb_cmd_data <= ~cb_cmd_data;
    repeat (half) @(posedge sys_clk);
    rd_word <= rd;
    frame_done <= 1'b1;
    @(posedge sys_clk);
    frame_done <= 1'b0;
  endtask
endmodule
